/* File: rtl/tofspi_target.sv */
// Sensor-side serial register port with a small register bank.
//
// How it works
// - Sample on rising, drive on falling edge.
// - Ignore clock and data while deselected.
// - Transaction starts only after select falls.
// - Select rising clears counters and command state.
// - Abort mid transfer leaves registers untouched.
// - Clock may pause arbitrarily within transfer.
// - Address bits echoed back on output.
// - One bit each way per clock.
// - Unused locations read zero; revision readable.
// - Writes to unused locations are ignored.
// - Write: one, fifteen address bits, data.
// - Further write bytes go to next address.
// - Read: zero then address only.
// - First read bit driven on next falling edge.
// - Host ends single read after eight bits.
// - Continued reading streams incrementing addresses.
// - Host stops clock, then deselects.
`timescale 1ns/1ps
`default_nettype none
module tofspi_target
  import tofspi_pkg::*;
(
  // System side.
  input wire logic clock_i,
  input wire logic srst_i,
  // Serial link.
  tofspi_if.device link,
  // Register view for the sensor core.
  output logic [7:0] ctrl0_o,
  output logic write_seen_o
);
  import tofspi_pkg::*;

  // Link domain logic; the select line is an asynchronous reset for it, except the register bank and the write toggle.
  logic [4:0] hdr_cnt_q;
  logic [2:0] bit_cnt_q;
  logic hdr_done_q;
  logic wr_q;
  logic [14:0] addr_q;
  logic [15:0] hdr_sr_q;
  logic [7:0] din_q;
  logic [7:0] dout_q;
  logic miso_q;
  logic [7:0] regs_q [0:59];
  logic wr_tog_q;
  logic [7:0] rd_byte;

  // Read map: writable bank below the read-only area, revision on top, zero elsewhere.
  function automatic logic [7:0] rd_reg(input logic [14:0] a);
    logic [7:0] v;
    v = UNUSED_VAL;
    if (a < RO_BASE) begin
      v = regs_q[a[5:0]];
    end else if (a == REV_ADDR) begin
      v = REV_VAL;
    end
    return v;
  endfunction : rd_reg

  wire logic [15:0] hdr_next = {hdr_sr_q[14:0], link.mosi};
  wire logic [7:0] byte_next = {din_q[6:0], link.mosi};

  // Read data follows the current address and the bank contents.
  always_comb begin
    rd_byte = rd_reg(addr_q);
  end

  // Header phase: direction bit then address, one bit per rising edge.
  // A stopped clock simply holds every register where it is.
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      hdr_cnt_q <= CNT_RST;
      hdr_done_q <= 1'b0;
    end else if (!hdr_done_q) begin
      hdr_cnt_q <= hdr_cnt_q + 5'h01;
      if (hdr_cnt_q == HDR_LAST) begin
        hdr_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      hdr_sr_q <= 16'h0000;
    end else if (!hdr_done_q) begin
      hdr_sr_q <= hdr_next;
    end
  end

  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      wr_q <= 1'b0;
    end else if (!hdr_done_q && hdr_cnt_q == HDR_LAST) begin
      wr_q <= hdr_next[15];
    end
  end

  // The address loads at the end of the header and then steps once per byte.
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      addr_q <= 15'h0000;
    end else if (!hdr_done_q) begin
      if (hdr_cnt_q == HDR_LAST) begin
        addr_q <= hdr_next[14:0];
      end
    end else if (bit_cnt_q == BIT_LAST) begin
      addr_q <= addr_q + 15'h0001;
    end
  end

  // Data phase: eight rising edges per byte, then the counter wraps.
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_q <= 3'h0;
      din_q <= 8'h00;
    end else if (hdr_done_q) begin
      din_q <= byte_next;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Register bank write only on a complete byte; a byte cut short by select
  // rising never gets here because the link state clears first.
  always_ff @(posedge link.sclk) begin
    if (!link.cs_n && hdr_done_q && wr_q && bit_cnt_q == BIT_LAST) begin
      if (addr_q < RO_BASE) begin
        regs_q[addr_q[5:0]] <= byte_next;
      end
    end
  end

  // Toggle marks every accepted write for the system domain.
  // The system reset clears it while the link clock stands high at rest.
  always_ff @(posedge link.sclk or posedge srst_i) begin
    if (srst_i) begin
      wr_tog_q <= 1'b0;
    end else if (!link.cs_n && hdr_done_q && wr_q && bit_cnt_q == BIT_LAST && addr_q < RO_BASE) begin
      wr_tog_q <= ~wr_tog_q;
    end
  end

  // Falling edge launch of the outgoing bit; it stays low through write data.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      miso_q <= 1'b0;
    end else if (!hdr_done_q) begin
      miso_q <= hdr_sr_q[0];
    end else if (wr_q) begin
      miso_q <= 1'b0;
    end else if (bit_cnt_q == 3'h0) begin
      miso_q <= rd_byte[7];
    end else begin
      miso_q <= dout_q[7];
    end
  end

  // Each byte is fetched at its first falling edge and shifted at the others.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      dout_q <= 8'h00;
    end else if (hdr_done_q && bit_cnt_q == 3'h0) begin
      dout_q <= {rd_byte[6:0], 1'b0};
    end else if (hdr_done_q) begin
      dout_q <= {dout_q[6:0], 1'b0};
    end
  end

  assign link.miso = miso_q;

  // Crossing into the system clock: two flip-flops settle the toggle and the
  // third only marks its edge; register 0 is stable long before that edge.
  logic [2:0] tog_sync_q;
  logic [7:0] ctrl0_q;
  logic seen_q;
  logic tog_edge;
  assign tog_edge = tog_sync_q[2] ^ tog_sync_q[1];

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tog_sync_q <= 3'h0;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], wr_tog_q};
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= tog_edge;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl0_q <= REG_RST;
    end else if (tog_edge) begin
      ctrl0_q <= regs_q[0];
    end
  end
  assign ctrl0_o = ctrl0_q;
  assign write_seen_o = seen_q;
endmodule : tofspi_target
`default_nettype wire

/* File: rtl/tofspi_pkg.sv */
// Shared constants for the serial register port and its controller.
package tofspi_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned HDR_BITS = 16;
  localparam logic [4:0] HDR_LAST = 5'h0f;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [7:0] UNUSED_VAL = 8'h00;
  localparam logic [14:0] REG_COUNT = 15'h0040;
  localparam logic [14:0] RO_BASE = 15'h003c;
  localparam logic [14:0] REV_ADDR = 15'h003f;
  // Arbitrary value standing for a design revision code.
  localparam logic [7:0] REV_VAL = 8'h5a;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] CLK_DIV = 4'h4;
  localparam logic [3:0] DIV_RST = 4'h0;
  typedef enum logic [2:0] {
    TOFSPI_IDLE = 3'b000,
    TOFSPI_SEL = 3'b001,
    TOFSPI_SHIFT = 3'b011,
    TOFSPI_DONE = 3'b010
  } tofspi_state_t;
endpackage : tofspi_pkg

/* File: rtl/tofspi_if.sv */
// Four-wire serial link between the controller and the sensor register port.
`timescale 1ns/1ps
`default_nettype none
interface tofspi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : tofspi_if
`default_nettype wire

/* File: rtl/tofspi_host.sv */
// Controller end: runs one single-byte register write or read on request.
`timescale 1ns/1ps
`default_nettype none
module tofspi_host
  import tofspi_pkg::*;
(
  // System side.
  input wire logic clock_i,
  input wire logic srst_i,
  // Request.
  input wire logic start_i,
  input wire logic wr_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  // Serial link.
  tofspi_if.host link
);
  import tofspi_pkg::*;

  tofspi_state_t state_q;
  logic [3:0] div_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic [23:0] sr_q;
  logic [4:0] cnt_q;
  logic [7:0] rd_q;
  logic [1:0] miso_s_q;
  logic done_q;
  logic busy_q;

  wire logic tick = (div_q == CLK_DIV);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_q <= DIV_RST;
    end else begin
      div_q <= tick ? DIV_RST : div_q + 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      miso_s_q <= 2'b00;
    end else begin
      miso_s_q <= {miso_s_q[0], link.miso};
    end
  end

  // Idle-high clock; data changes on falling, sampled on rising.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= TOFSPI_IDLE;
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      sr_q <= 24'h000000;
      cnt_q <= 5'h00;
      rd_q <= 8'h00;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        TOFSPI_IDLE: begin
          if (start_i) begin
            cs_n_q <= 1'b0;
            busy_q <= 1'b1;
            sr_q <= {wr_i, addr_i, wdata_i};
            cnt_q <= 5'h00;
            state_q <= TOFSPI_SEL;
          end
        end
        TOFSPI_SEL: begin
          if (tick) begin
            state_q <= TOFSPI_SHIFT;
          end
        end
        TOFSPI_SHIFT: begin
          if (tick) begin
            if (sclk_q) begin
              sclk_q <= 1'b0;
              mosi_q <= sr_q[23];
              sr_q <= {sr_q[22:0], 1'b0};
            end else begin
              sclk_q <= 1'b1;
              rd_q <= {rd_q[6:0], miso_s_q[1]};
              cnt_q <= cnt_q + 5'h01;
              if (cnt_q == 5'h17) begin
                state_q <= TOFSPI_DONE;
              end
            end
          end
        end
        TOFSPI_DONE: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= TOFSPI_IDLE;
          end
        end
        default: begin
          state_q <= TOFSPI_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rdata_o = rd_q;
endmodule : tofspi_host
`default_nettype wire

/* File: verif/tofspi_properties.sv */
// Link checks for the controller and register port pair.
`timescale 1ns/1ps
`default_nettype none
module tofspi_properties (
  // System side.
  input wire logic clock_i,
  input wire logic srst_i,
  // Serial link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_q, mosi_q, wr_q, rise;
  logic [4:0] cnt_q;
  assign rise = sclk && !sclk_q && !cs_n;
  always_ff @(posedge clock_i) begin
    sclk_q <= sclk;
    if (rise) mosi_q <= mosi;
    if (rise && cnt_q == 5'h00) wr_q <= mosi;
  end
  // Counts rising clock edges seen in the current frame.
  always_ff @(posedge clock_i) begin
    if (srst_i || cs_n) cnt_q <= 5'h00;
    else if (rise) cnt_q <= cnt_q + 5'h01;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_first_fall; ##[1:12] $fell(sclk); endsequence
  property p_idle; cs_n |-> sclk; endproperty
  property p_mosi; $changed(mosi) && !cs_n && !$past(cs_n) |-> $fell(sclk); endproperty
  property p_miso; $changed(miso) && !cs_n && !$past(cs_n) |-> $fell(sclk); endproperty
  property p_start; $fell(cs_n) |-> s_first_fall; endproperty
  property p_len; $rose(cs_n) |-> cnt_q == 5'h18; endproperty
  property p_echo; rise && cnt_q >= 5'h01 && cnt_q <= 5'h0f |-> miso == mosi_q; endproperty
  property p_wzero; rise && wr_q && cnt_q >= 5'h10 |-> !miso; endproperty
  property p_stop; $rose(cs_n) |-> $past(sclk, 4); endproperty
  a_idle: assert property (p_idle) else $error("clock low while deselected");
  a_mosi: assert property (p_mosi) else $error("mosi moved off a falling edge");
  a_miso: assert property (p_miso) else $error("miso moved off a falling edge");
  a_start: assert property (p_start) else $error("no clock after select");
  a_len: assert property (p_len) else $error("frame length wrong");
  a_echo: assert property (p_echo) else $error("address echo wrong");
  a_wzero: assert property (p_wzero) else $error("miso not low in write data");
  a_stop: assert property (p_stop) else $error("deselect while clock active");
endmodule : tofspi_properties
`default_nettype wire

/* File: verif/tof_sensor_spi_target_port_test.sv */
// Controller against register port, plus a bit-level driver on a second port.
`timescale 1ns/1ps
`default_nettype none
module tof_sensor_spi_target_port_test;
  import tofspi_pkg::*;
  localparam logic [14:0] WA [4] = '{15'h0000, 15'h003b, 15'h003f, 15'h0050};
  localparam logic [7:0] WD [4] = '{8'ha5, 8'h3c, 8'h11, 8'hee};
  localparam logic [14:0] RA [6] = '{15'h0000, 15'h003b, 15'h003f, 15'h003c, 15'h0050, 15'h7fff};
  localparam logic [7:0] RD [6] = '{8'ha5, 8'h3c, REV_VAL, 8'h00, 8'h00, 8'h00};
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_i = 1'b0;
  logic wr_i = 1'b0;
  logic [14:0] addr_i = 15'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic busy_o, done_o, seen_o;
  logic [7:0] rdata_o, ctrl0_o, ctrl0_b;
  logic [31:0] got;
  int errors = 0;
  int comparisons = 0;
  int seen_cnt = 0;
  tofspi_if link_a ();
  tofspi_if link_b ();
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  tofspi_host tofspi_host_inst (.clock_i(clock_i), .srst_i(srst_i), .start_i(start_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .link(link_a.host));
  tofspi_target tofspi_target_inst (.clock_i(clock_i), .srst_i(srst_i), .link(link_a.device),
    .ctrl0_o(ctrl0_o), .write_seen_o(seen_o));
  tofspi_target tofspi_target_inst2 (.clock_i(clock_i), .srst_i(srst_i), .link(link_b.device),
    .ctrl0_o(ctrl0_b), .write_seen_o());
  tofspi_properties tofspi_properties_inst (.clock_i(clock_i), .srst_i(srst_i), .sclk(link_a.sclk),
    .cs_n(link_a.cs_n), .mosi(link_a.mosi), .miso(link_a.miso));
  always @(posedge clock_i) if (seen_o === 1'b1) seen_cnt++;
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [14:0] addr, input logic [7:0] wdata);
    int n;
    @(negedge clock_i);
    wr_i = wr;
    addr_i = addr;
    wdata_i = wdata;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    check("busy", 32'h1, {31'h0, busy_o});
    for (n = 0; n < 400 && done_o !== 1'b1; n++) @(negedge clock_i);
    if (n == 400) begin
      errors++;
      $display("BAD done expected 1 seen %b", done_o);
      print_verdict();
    end
    repeat (6) @(negedge clock_i);
    check("idle", 32'h0, {31'h0, busy_o});
  endtask : xfer
  // Drives a frame on the second port at a 15 ns clock; a pause holds the clock high.
  task automatic bang(input logic [31:0] bits, input int n, input int pause_at);
    int i;
    got = 32'h0;
    link_b.cs_n = 1'b0;
    #7.5;
    for (i = 0; i < n; i++) begin
      link_b.sclk = 1'b0;
      link_b.mosi = bits[31 - i];
      #7.5;
      link_b.sclk = 1'b1;
      got = {got[30:0], link_b.miso};
      if (i == pause_at) #500;
      else #7.5;
    end
    link_b.cs_n = 1'b1;
    link_b.mosi = ~link_b.mosi;
    #90;
  endtask : bang
  initial begin
    link_b.sclk = 1'b1;
    link_b.cs_n = 1'b1;
    link_b.mosi = 1'b0;
    repeat (3) @(negedge clock_i);
    // A clock pulse while deselected brings the second port out of its unknown state.
    link_b.sclk = 1'b0;
    repeat (2) @(negedge clock_i);
    link_b.sclk = 1'b1;
    repeat (5) @(negedge clock_i);
    srst_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, WA[k], WD[k]);
      if (k == 0) check("seen", 32'h1, seen_cnt);
    end
    check("ctrl0", 32'ha5, {24'h0, ctrl0_o});
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, RA[k], 8'h00);
      check("rdata", {24'h0, RD[k]}, {24'h0, rdata_o});
    end
    bang({1'b1, 15'h0000, 16'h3c77}, 32, 20);
    bang({1'b1, 15'h0000, 16'h5500}, 20, 99);
    check("ctrl0_b", 32'h3c, {24'h0, ctrl0_b});
    bang({1'b0, 15'h0000, 16'h0000}, 32, 99);
    check("burst", 32'h3c77, {16'h0, got[15:0]});
    print_verdict();
  end
endmodule : tof_sensor_spi_target_port_test
`default_nettype wire
